// >>> design/kcs_pkg.sv
// package of the key-click sounder: register map, field layout, timing
// assumes a single 250 MHz clock domain; no tool-specific constructs
package kcs_pkg;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] REG_CLICK_TONE_CONFIG  = 8'h07;
  localparam logic [7:0] REG_VERSION_DESCRIPTOR = 8'h14;
  localparam int         BIT_CLICK_LENGTH_SELECT = 2;
  localparam int         BIT_TONE_PITCH_SELECT   = 1;
  localparam int         BIT_TONE_OUTPUT_ENABLE  = 0;
  localparam logic [2:0] CFG_RESET               = 3'h0;
  // i2c device address; value is arbitrary
  localparam logic [6:0] DEV_ADDR                = 7'h5c;

  // descriptor text; content is arbitrary, null byte appended on read
  localparam int         DESC_LEN  = 29;
  localparam logic [8*DESC_LEN-1:0] DESC_TEXT =
    "VNDR,PN:CLK1,QUAL:ENG,VER:1_0";

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned CLICK_SHORT_MS  = 10;
  localparam int unsigned CLICK_LONG_MS   = 20;
  localparam int unsigned TONE_LOW_HZ     = 1000;
  localparam int unsigned TONE_HIGH_HZ    = 2000;
  localparam int unsigned CLICK_SHORT_CYC = CLK_HZ / 1000 * CLICK_SHORT_MS;
  localparam int unsigned CLICK_LONG_CYC  = CLK_HZ / 1000 * CLICK_LONG_MS;
  localparam int unsigned HALF_LOW_CYC    = CLK_HZ / (2 * TONE_LOW_HZ);
  localparam int unsigned HALF_HIGH_CYC   = CLK_HZ / (2 * TONE_HIGH_HZ);
  localparam int          LEN_W           = 23;
  localparam int          HALF_W          = 17;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic click_length_select;
    logic tone_pitch_select;
    logic tone_output_enable;
  } kcs_cfg_t;

  typedef enum logic [8:0] {
    I_IDLE = 9'h001,
    I_ADDR = 9'h002,
    I_AACK = 9'h004,
    I_REG  = 9'h008,
    I_DACK = 9'h010,
    I_WDAT = 9'h020,
    I_RDAT = 9'h040,
    I_MACK = 9'h080,
    I_SKIP = 9'h100
  } kcs_i2c_st_t;

  typedef enum logic [1:0] {
    T_IDLE  = 2'h1,
    T_CLICK = 2'h2
  } kcs_tone_st_t;

  typedef struct packed {
    kcs_tone_st_t      st;
    logic [LEN_W-1:0]  len_cnt;
    logic [HALF_W-1:0] half_cnt;
    logic              tone;
  } kcs_tone_s_t;

  typedef struct packed {
    kcs_i2c_st_t st;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic [4:0]  desc_idx;
    logic        sda_oe;
    logic        sda_lvl;
    kcs_cfg_t    cfg;
  } kcs_i2c_s_t;

  // one descriptor character per index, null past the end
  function automatic logic [7:0] desc_char(input logic [4:0] idx);
    if (int'(idx) >= DESC_LEN) begin
      return 8'h00;
    end
    return DESC_TEXT[8*(DESC_LEN-1-int'(idx)) +: 8];
  endfunction

endpackage

// >>> design/kcs_tone_gen.sv
// click tone generator: one click per touch pulse while idle, square wave output
// assumes cfg is a registered level and touch is a one-cycle pulse
`timescale 1ns/1ns
module kcs_tone_gen #(
  parameter int unsigned CLICK_SHORT = kcs_pkg::CLICK_SHORT_CYC,
  parameter int unsigned CLICK_LONG  = kcs_pkg::CLICK_LONG_CYC,
  parameter int unsigned HALF_LOW    = kcs_pkg::HALF_LOW_CYC,
  parameter int unsigned HALF_HIGH   = kcs_pkg::HALF_HIGH_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire kcs_pkg::kcs_cfg_t cfg,
  input  wire logic              touch,
  output logic                   tone_out
);

  kcs_pkg::kcs_tone_s_t s_r;
  kcs_pkg::kcs_tone_s_t s_nxt;
  logic [kcs_pkg::LEN_W-1:0]  len_last;
  logic [kcs_pkg::HALF_W-1:0] half_last;

  // ****************************************
  // click sequencing
  // ****************************************
  // no bus signal reaches this module, so a click never waits on i2c
  assign len_last  = kcs_pkg::LEN_W'(cfg.click_length_select ?
                     CLICK_LONG - 1 : CLICK_SHORT - 1);
  assign half_last = kcs_pkg::HALF_W'(cfg.tone_pitch_select ?
                     HALF_HIGH - 1 : HALF_LOW - 1);

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      kcs_pkg::T_IDLE: begin
        s_nxt.tone = 1'b0;
        if (touch && cfg.tone_output_enable) begin
          s_nxt.st       = kcs_pkg::T_CLICK;
          s_nxt.len_cnt  = '0;
          s_nxt.half_cnt = '0;
        end
      end
      kcs_pkg::T_CLICK: begin
        s_nxt.len_cnt = s_r.len_cnt + 1'b1;
        if (s_r.half_cnt >= half_last) begin
          s_nxt.half_cnt = '0;
          s_nxt.tone     = ~s_r.tone;
        end else begin
          s_nxt.half_cnt = s_r.half_cnt + 1'b1;
        end
        // a pitch change mid-click is caught by the >= compare
        if (s_r.len_cnt >= len_last) begin
          s_nxt.st   = kcs_pkg::T_IDLE;
          s_nxt.tone = 1'b0;
        end
      end
      default: begin
        s_nxt.st   = kcs_pkg::T_IDLE;
        s_nxt.tone = 1'b0;
      end
    endcase
    if (!cfg.tone_output_enable) begin
      s_nxt.st   = kcs_pkg::T_IDLE;
      s_nxt.tone = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{st: kcs_pkg::T_IDLE, len_cnt: '0, half_cnt: '0, tone: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tone_out = s_r.tone;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_disable_idle: assert property (!cfg.tone_output_enable |=> !tone_out
    && s_r.st == kcs_pkg::T_IDLE) else $error("tone active while off");
  a_touch_starts: assert property (touch && cfg.tone_output_enable
    && s_r.st == kcs_pkg::T_IDLE |=> s_r.st == kcs_pkg::T_CLICK)
    else $error("touch did not start click");
  a_click_length: assert property (s_r.st == kcs_pkg::T_CLICK
    && s_r.len_cnt == len_last |=> s_r.st == kcs_pkg::T_IDLE && !tone_out)
    else $error("click length wrong");
  a_click_runs: assert property (s_r.st == kcs_pkg::T_CLICK
    && s_r.len_cnt < len_last && cfg.tone_output_enable
    |=> s_r.st == kcs_pkg::T_CLICK) else $error("click stalled");
  a_half_period: assert property (s_r.st == kcs_pkg::T_CLICK
    && $changed(tone_out) |-> $past(s_r.half_cnt) == $past(half_last))
    else $error("tone toggled off period");
  a_idle_quiet: assert property (s_r.st == kcs_pkg::T_IDLE |-> !tone_out)
    else $error("tone toggling while idle");

  c_click_start: cover property (touch && cfg.tone_output_enable
    && s_r.st == kcs_pkg::T_IDLE);
  c_long_high: cover property (s_r.st == kcs_pkg::T_CLICK
    && cfg.click_length_select && cfg.tone_pitch_select && $rose(tone_out));

endmodule

// >>> design/kcs_top.sv
// key-click sounder top: i2c register slave plus click tone generator
// assumes scl/sda inputs already synchronous to sys_clk, pull-up external
`timescale 1ns/1ns

// Overview of operation
// - click tones run independent of any i2c transfer in progress
// - sounder pin toggles as a square wave during each click
// - config bit 2 picks click length: 0 gives 10 ms, 1 gives 20 ms
// - config bit 1 picks pitch: 0 gives 1 kHz, 1 gives 2 kHz
// - config bit 0 enables the sounder; cleared keeps the pin idle
// - descriptor at 0x14 is read-only fixed data; writes do nothing
// - burst reads of descriptor return ascii text ending in null
// - sounder config register sits at address 0x07
module kcs_top #(
  parameter int unsigned CLICK_SHORT = kcs_pkg::CLICK_SHORT_CYC,
  parameter int unsigned CLICK_LONG  = kcs_pkg::CLICK_LONG_CYC,
  parameter int unsigned HALF_LOW    = kcs_pkg::HALF_LOW_CYC,
  parameter int unsigned HALF_HIGH   = kcs_pkg::HALF_HIGH_CYC
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic touch_event,
  output logic      tone_out
);

  kcs_pkg::kcs_i2c_s_t s_r;
  kcs_pkg::kcs_i2c_s_t s_nxt;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_c;
  logic                stop_c;
  logic [7:0]          rd_byte;

  // ****************************************
  // bus condition detect
  // ****************************************
  assign scl_rise = scl_in & ~s_r.scl_q;
  assign scl_fall = ~scl_in & s_r.scl_q;
  assign start_c  = scl_in & s_r.scl_q & s_r.sda_q & ~sda_in;
  assign stop_c   = scl_in & s_r.scl_q & ~s_r.sda_q & sda_in;

  // read data for the current pointer; descriptor index walks the text
  function automatic logic [7:0] read_byte(input kcs_pkg::kcs_i2c_s_t s);
    case (s.ptr)
      kcs_pkg::REG_CLICK_TONE_CONFIG:  return {5'h00, s.cfg};
      kcs_pkg::REG_VERSION_DESCRIPTOR: return kcs_pkg::desc_char(s.desc_idx);
      default:                         return 8'h00;
    endcase
  endfunction

  assign rd_byte = read_byte(s_r);

  // ****************************************
  // i2c slave
  // ****************************************
  // no clock stretching is used: every answer is ready at the scl fall
  always_comb begin
    s_nxt       = s_r;
    s_nxt.scl_q = scl_in;
    s_nxt.sda_q = sda_in;
    if (scl_rise && (s_r.st == kcs_pkg::I_ADDR || s_r.st == kcs_pkg::I_REG
        || s_r.st == kcs_pkg::I_WDAT)) begin
      s_nxt.shreg  = {s_r.shreg[6:0], sda_in};
      s_nxt.bitcnt = s_r.bitcnt + 1'b1;
    end
    case (s_r.st)
      kcs_pkg::I_IDLE, kcs_pkg::I_SKIP: begin
        s_nxt.sda_oe = 1'b0;
      end
      kcs_pkg::I_ADDR: begin
        if (scl_fall && s_r.bitcnt == 4'h8) begin
          if (s_r.shreg[7:1] == kcs_pkg::DEV_ADDR) begin
            s_nxt.st     = kcs_pkg::I_AACK;
            s_nxt.sda_oe = 1'b1;
          end else begin
            s_nxt.st = kcs_pkg::I_SKIP;
          end
        end
      end
      kcs_pkg::I_AACK: begin
        if (scl_fall) begin
          s_nxt.bitcnt = 4'h0;
          if (s_r.shreg[0]) begin
            s_nxt.st     = kcs_pkg::I_RDAT;
            s_nxt.shreg  = rd_byte;
            s_nxt.sda_oe = ~rd_byte[7];
            if (s_r.ptr == kcs_pkg::REG_VERSION_DESCRIPTOR
                && s_r.desc_idx < 5'(kcs_pkg::DESC_LEN)) begin
              s_nxt.desc_idx = s_r.desc_idx + 1'b1;
            end
          end else begin
            s_nxt.st     = kcs_pkg::I_REG;
            s_nxt.sda_oe = 1'b0;
          end
        end
      end
      kcs_pkg::I_REG: begin
        if (scl_fall && s_r.bitcnt == 4'h8) begin
          s_nxt.ptr      = s_r.shreg;
          s_nxt.desc_idx = 5'h00;
          s_nxt.st       = kcs_pkg::I_DACK;
          s_nxt.sda_oe   = 1'b1;
        end
      end
      kcs_pkg::I_WDAT: begin
        if (scl_fall && s_r.bitcnt == 4'h8) begin
          s_nxt.st     = kcs_pkg::I_DACK;
          s_nxt.sda_oe = 1'b1;
          // the descriptor has no write path at all
          if (s_r.ptr == kcs_pkg::REG_CLICK_TONE_CONFIG) begin
            s_nxt.cfg = s_r.shreg[2:0];
          end
          if (s_r.ptr != kcs_pkg::REG_VERSION_DESCRIPTOR) begin
            s_nxt.ptr = s_r.ptr + 1'b1;
          end
        end
      end
      kcs_pkg::I_DACK: begin
        if (scl_fall) begin
          s_nxt.st     = kcs_pkg::I_WDAT;
          s_nxt.bitcnt = 4'h0;
          s_nxt.sda_oe = 1'b0;
        end
      end
      kcs_pkg::I_RDAT: begin
        if (scl_fall) begin
          if (s_r.bitcnt == 4'h7) begin
            s_nxt.st     = kcs_pkg::I_MACK;
            s_nxt.sda_oe = 1'b0;
          end else begin
            s_nxt.shreg  = {s_r.shreg[6:0], 1'b0};
            s_nxt.sda_oe = ~s_r.shreg[6];
            s_nxt.bitcnt = s_r.bitcnt + 1'b1;
          end
        end
      end
      kcs_pkg::I_MACK: begin
        if (scl_rise && sda_in) begin
          s_nxt.st = kcs_pkg::I_SKIP;
        end else if (scl_fall) begin
          s_nxt.st     = kcs_pkg::I_RDAT;
          s_nxt.bitcnt = 4'h0;
          s_nxt.shreg  = rd_byte;
          s_nxt.sda_oe = ~rd_byte[7];
          if (s_r.ptr == kcs_pkg::REG_VERSION_DESCRIPTOR) begin
            if (s_r.desc_idx < 5'(kcs_pkg::DESC_LEN)) begin
              s_nxt.desc_idx = s_r.desc_idx + 1'b1;
            end
          end else begin
            s_nxt.ptr = s_r.ptr + 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st     = kcs_pkg::I_IDLE;
        s_nxt.sda_oe = 1'b0;
      end
    endcase
    // a repeated start restarts the descriptor text from its first letter
    if (start_c) begin
      s_nxt.st       = kcs_pkg::I_ADDR;
      s_nxt.bitcnt   = 4'h0;
      s_nxt.sda_oe   = 1'b0;
      s_nxt.desc_idx = 5'h00;
    end else if (stop_c) begin
      s_nxt.st     = kcs_pkg::I_IDLE;
      s_nxt.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{st: kcs_pkg::I_IDLE, scl_q: 1'b1, sda_q: 1'b1, bitcnt: 4'h0,
               shreg: 8'h00, ptr: 8'h00, desc_idx: 5'h00, sda_oe: 1'b0,
               sda_lvl: 1'b0, cfg: kcs_pkg::CFG_RESET};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_out = s_r.sda_lvl;
  assign sda_oe  = s_r.sda_oe;

  // ****************************************
  // tone generator
  // ****************************************
  kcs_tone_gen #(
    .CLICK_SHORT (CLICK_SHORT),
    .CLICK_LONG  (CLICK_LONG),
    .HALF_LOW    (HALF_LOW),
    .HALF_HIGH   (HALF_HIGH)
  ) u_tone (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .cfg      (s_r.cfg),
    .touch    (touch_event),
    .tone_out (tone_out)
  );

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_desc_no_write: assert property (s_r.st == kcs_pkg::I_WDAT && scl_fall
    && s_r.bitcnt == 4'h8 && s_r.ptr == kcs_pkg::REG_VERSION_DESCRIPTOR
    |=> $stable(s_r.cfg) && $stable(s_r.ptr))
    else $error("descriptor write had effect");
  a_cfg_write: assert property (s_r.st == kcs_pkg::I_WDAT && scl_fall
    && s_r.bitcnt == 4'h8 && s_r.ptr == kcs_pkg::REG_CLICK_TONE_CONFIG
    |=> s_r.cfg == $past(s_r.shreg[2:0]))
    else $error("config write lost");
  a_desc_char: assert property (s_r.st == kcs_pkg::I_MACK && scl_fall
    && !start_c && !stop_c && s_r.ptr == kcs_pkg::REG_VERSION_DESCRIPTOR
    |=> s_r.shreg == kcs_pkg::desc_char($past(s_r.desc_idx)))
    else $error("descriptor byte wrong");
  a_read_release: assert property (s_r.st == kcs_pkg::I_RDAT && scl_fall
    && s_r.bitcnt == 4'h7 && !start_c && !stop_c
    |=> !sda_oe ##1 s_r.st != kcs_pkg::I_RDAT || s_r.bitcnt == 4'h0)
    else $error("sda held into master ack");

  c_cfg_write: cover property (s_r.st == kcs_pkg::I_WDAT && scl_fall
    && s_r.ptr == kcs_pkg::REG_CLICK_TONE_CONFIG && s_r.bitcnt == 4'h8);
  c_desc_null: cover property (s_r.st == kcs_pkg::I_RDAT
    && s_r.ptr == kcs_pkg::REG_VERSION_DESCRIPTOR && s_r.shreg == 8'h00);

endmodule

// >>> verification/kcs_host.sv
// i2c host model: start, stop and byte transfers on the open-drain bus
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
module kcs_host #(
  parameter int Q = 10
) (
  input  wire logic       sys_clk,
  input  wire logic       sda_in,
  input  wire logic       scl_in,
  output logic            scl,
  output logic            sda_low,
  output logic            res_stb,
  output logic [7:0]      res_byte
);
  initial begin
    scl      = 1'b1;
    sda_low  = 1'b0;
    res_stb  = 1'b0;
    res_byte = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // sda only moves while scl is low, except inside start and stop
  task automatic start();
    sda_low = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_low = 1'b1;
    tick(Q);
    scl = 1'b0;
    tick(Q);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_low = 1'b0;
    tick(Q);
  endtask

  task automatic bitx(input logic b, output logic r);
    sda_low = ~b;
    tick(Q);
    scl = 1'b1;
    // the slave may hold the clock low; the high phase counts from release
    tick(1);
    while (scl_in !== 1'b1) begin
      tick(1);
    end
    tick(Q - 1);
    r   = sda_in;
    scl = 1'b0;
    tick(Q);
  endtask

  // reads release sda for the data bits, then ack unless last
  task automatic xfer(input logic [7:0] d, input logic rd, input logic last);
    logic [7:0] v;
    logic       a;
    for (int i = 7; i >= 0; i--) begin
      bitx(rd | d[i], v[i]);
    end
    bitx(rd ? last : 1'b1, a);
    res_byte = rd ? v : {7'h00, a};
    res_stb  = 1'b1;
    tick(1);
    res_stb  = 1'b0;
  endtask
endmodule

// >>> verification/tb_top.sv
// bench of the key-click sounder: register traffic and click timing
// assumes the host model drives the bus; counts shortened by parameters
`timescale 1ns/1ns
module tb_top;
  localparam int CS = 40;
  localparam int CL = 80;
  localparam int HL = 8;
  localparam int HH = 4;
  localparam logic [7:0] RC = kcs_pkg::REG_CLICK_TONE_CONFIG;
  localparam logic [7:0] RV = kcs_pkg::REG_VERSION_DESCRIPTOR;

  logic        sys_clk;
  logic        reset_n;
  logic        touch_event;
  logic        scl;
  logic        sda_low;
  logic        res_stb;
  logic [7:0]  res_byte;
  logic        sda_out;
  logic        sda_oe;
  logic        tone_out;
  logic [7:0]  cfg;
  wire logic   sda_w;
  int          mismatches;
  int          n_compared;
  int          seed;
  logic [7:0]  exp_rd[$];
  logic [15:0] exp_tone[$];

  assign sda_w = ~(sda_low | (sda_oe & ~sda_out));

  kcs_host u_host (
    .sys_clk  (sys_clk),
    .sda_in   (sda_w),
    .scl_in   (scl),
    .scl      (scl),
    .sda_low  (sda_low),
    .res_stb  (res_stb),
    .res_byte (res_byte)
  );

  kcs_top #(
    .CLICK_SHORT (CS),
    .CLICK_LONG  (CL),
    .HALF_LOW    (HL),
    .HALF_HIGH   (HH)
  ) u_dut (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .scl_in      (scl),
    .sda_in      (sda_w),
    .sda_out     (sda_out),
    .sda_oe      (sda_oe),
    .touch_event (touch_event),
    .tone_out    (tone_out)
  );

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] dchar(input int i);
    if (i >= kcs_pkg::DESC_LEN) begin
      return 8'h00;
    end
    return kcs_pkg::DESC_TEXT[8*(kcs_pkg::DESC_LEN-1-i) +: 8];
  endfunction

  task automatic sel(input logic [7:0] a);
    u_host.start();
    exp_rd.push_back(8'h00);
    u_host.xfer({kcs_pkg::DEV_ADDR, 1'b0}, 1'b0, 1'b0);
    exp_rd.push_back(8'h00);
    u_host.xfer(a, 1'b0, 1'b0);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    sel(a);
    exp_rd.push_back(8'h00);
    u_host.xfer(d, 1'b0, 1'b0);
    u_host.stop();
  endtask

  // descriptor bytes are expected from the text, others equal e
  task automatic rreg(input logic [7:0] a, input int n, input logic [7:0] e);
    sel(a);
    u_host.start();
    exp_rd.push_back(8'h00);
    u_host.xfer({kcs_pkg::DEV_ADDR, 1'b1}, 1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      exp_rd.push_back(a == RV ? dchar(i) : e);
      u_host.xfer(8'hff, 1'b1, 1'(i == n - 1));
    end
    u_host.stop();
  endtask

  // expected: cycles to first rise and number of rises in one click
  task automatic click(input logic [2:0] c);
    int h;
    int l;
    h = c[1] ? HH : HL;
    l = c[2] ? CL : CS;
    exp_tone.push_back(c[0] ? {8'(h + 1), 8'(l / (2 * h))} : 16'h0000);
    @(negedge sys_clk);
    touch_event = 1'b1;
    @(negedge sys_clk);
    touch_event = 1'b0;
    repeat (100) @(negedge sys_clk);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // monitors
  // ****************************************
  initial begin
    forever begin
      @(posedge res_stb);
      chk("bus byte", {8'h00, res_byte}, {8'h00, exp_rd.pop_front()});
    end
  end

  initial begin
    int   first;
    int   rises;
    logic prev;
    forever begin
      @(posedge sys_clk iff touch_event === 1'b1);
      first = 0;
      rises = 0;
      // idle level; a pin stuck high then shows as a rise at the first look
      prev  = 1'b0;
      for (int n = 1; n <= 96; n++) begin
        @(negedge sys_clk);
        if (tone_out === 1'b1 && prev !== 1'b1) begin
          rises++;
          if (first == 0) begin
            first = n;
          end
        end
        prev = tone_out;
      end
      chk("tone", {8'(first), 8'(rises)}, exp_tone.pop_front());
      chk("tone idle", {15'h0, tone_out}, 16'h0000);
    end
  end

  // hang guard, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed        = 32'h6bde;
    mismatches  = 0;
    n_compared  = 0;
    reset_n     = 1'b0;
    touch_event = 1'b0;
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    chk("sda_oe", {15'h0, sda_oe}, 16'h0000);
    chk("tone_out", {15'h0, tone_out}, 16'h0000);
    rreg(RC, 1, 8'h00);
    click(3'h0);
    for (int i = 0; i < 8; i++) begin
      cfg      = 8'($random(seed));
      cfg[2:0] = 3'(i);
      wreg(RC, cfg);
      rreg(RC, 1, {5'h00, cfg[2:0]});
      click(cfg[2:0]);
    end
    rreg(8'h20, 1, 8'h00);
    wreg(RV, 8'($random(seed)));
    rreg(RC, 1, 8'h07);
    rreg(RV, 31, 8'h00);
    u_host.start();
    exp_rd.push_back(8'h01);
    u_host.xfer({kcs_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b0, 1'b0);
    u_host.stop();
    // click while the start and first address bits of a descriptor burst read are on the bus
    wreg(RC, 8'h07);
    fork
      click(3'h7);
      rreg(RV, 4, 8'h00);
    join
    complete_run();
  end
endmodule
